// ==== spbif_pkg.sv ====
// shared constants and types of the segmented packet bus
package spbif_pkg;
  localparam int unsigned NSEG       = 4;
  localparam int unsigned SEG_W      = 128;
  localparam int unsigned BUS_W      = NSEG * SEG_W;
  localparam int unsigned MTY_W      = 4;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned CNT_W      = 4;
  localparam int unsigned SLACK      = 4;
  localparam logic [CNT_W-1:0] RDY_LIMIT  = 4'h2;
  localparam logic [2:0]       SLACK_MAX  = 3'h4;
  localparam logic [MTY_W-1:0] ERR_MTY_MASK = 4'h8;
  localparam logic [MTY_W-1:0] MTY_NONE     = 4'h0;

  typedef struct packed {
    logic [SEG_W-1:0] data;
    logic             valid;
    logic             packet_first_transfer;
    logic             packet_last_transfer;
    logic             err;
    logic [MTY_W-1:0] mty;
  } spbif_seg_t;

  typedef spbif_seg_t [NSEG-1:0] spbif_bus_t;

  localparam int unsigned WORD_W = $bits(spbif_bus_t);

  // zero every field of a segment whose valid is low
  function automatic spbif_seg_t spbif_qualify(input spbif_seg_t s);
    spbif_seg_t r;
    r = s;
    if (!s.valid) begin
      r = '0;
    end
    if (!(s.valid && s.packet_last_transfer)) begin
      r.err = 1'b0;
      r.mty = MTY_NONE;
    end
    if (r.err) begin
      r.mty = r.mty & ERR_MTY_MASK;
    end
    return r;
  endfunction
endpackage

// ==== spbif_if.sv ====
// local_packet_bus carrier between device and user logic
`timescale 1ns/100ps
`default_nettype none
interface spbif_if
  import spbif_pkg::*;
(
  input wire logic clk_sys_i
);
  spbif_bus_t tx_bus;
  logic       tx_rdy;
  logic       tx_ovf;
  spbif_bus_t rx_bus;

  modport dev (
    input  clk_sys_i,
    input  tx_bus,
    output tx_rdy,
    output tx_ovf,
    output rx_bus
  );

  modport usr (
    input  clk_sys_i,
    output tx_bus,
    input  tx_rdy,
    input  tx_ovf,
    input  rx_bus
  );
endinterface
`default_nettype wire

// ==== spbif_dev.sv ====
// device end of the local_packet_bus with its transmit fifo
`timescale 1ns/100ps
`default_nettype none
module spbif_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_sys_i,
  input  wire logic             sys_rst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } spbif_fifo_st_t;

  spbif_fifo_st_t st;
  spbif_fifo_st_t next_st;
  logic           push;
  logic           pop;

  always_comb begin
    next_st = st;
    pop  = (st.cnt != '0) && out_ready_i;
    push = in_valid_i && (st.cnt != FULL);
    if (push) begin
      next_st.mem[st.wr] = in_data_i;
      next_st.wr = st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = st.rd + 1'b1;
    end
    if (push && !pop) begin
      next_st.cnt = st.cnt + 1'b1;
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign in_ready_o  = (st.cnt != FULL);
  assign out_valid_o = (st.cnt != '0);
  assign out_data_o  = st.mem[st.rd];
  assign count_o     = st.cnt;
endmodule

// per-segment qualifier: idle segments read as zero, err and mty only on a last transfer
module spbif_seg_qual
  import spbif_pkg::*;
#(
  parameter logic [MTY_W-1:0] ERR_KEEP = ERR_MTY_MASK
) (
  input  wire spbif_seg_t seg_i,
  output var spbif_seg_t  seg_o
);
  logic tail;

  always_comb begin
    tail  = seg_i.valid && seg_i.packet_last_transfer;
    seg_o = '0;
    if (seg_i.valid) begin
      seg_o = seg_i;
    end
    if (!tail) begin
      seg_o.err = 1'b0;
      seg_o.mty = MTY_NONE;
    end
    if (seg_o.err) begin
      // error words keep only the top bit of the empty count
      seg_o.mty = seg_o.mty & ERR_KEEP;
    end
  end
endmodule

module spbif_dev
  import spbif_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  spbif_if.dev            bus,
  output spbif_bus_t      line_tx_o,
  output logic            line_tx_valid_o,
  input  wire logic       line_tx_ready_i,
  input  wire spbif_bus_t line_rx_i
);
  typedef struct packed {
    spbif_bus_t line_tx;
    logic       line_tx_valid;
    logic       tx_rdy;
    logic       tx_ovf;
    logic [2:0] slack;
    spbif_bus_t rx_bus;
  } spbif_dev_st_t;

  spbif_dev_st_t        st;
  spbif_dev_st_t        next_st;
  wire spbif_bus_t      tx_word;
  wire spbif_bus_t      rx_word;
  logic                 tx_push;
  logic                 fifo_in_ready;
  spbif_bus_t           fifo_out;
  logic                 fifo_out_valid;
  logic                 fifo_pop;
  logic [CNT_W-1:0]     fifo_cnt;

  // one qualifier per segment and direction
  for (genvar g = 0; g < NSEG; g++) begin : g_qual
    spbif_seg_qual #(
      .ERR_KEEP (ERR_MTY_MASK)
    ) u_tx_qual (
      .seg_i (bus.tx_bus[g]),
      .seg_o (tx_word[g])
    );
    spbif_seg_qual #(
      .ERR_KEEP (ERR_MTY_MASK)
    ) u_rx_qual (
      .seg_i (line_rx_i[g]),
      .seg_o (rx_word[g])
    );
  end

  // any valid segment makes the cycle a write
  always_comb begin
    tx_push = 1'b0;
    for (int i = 0; i < NSEG; i++) begin
      tx_push = tx_push | tx_word[i].valid;
    end
  end

  spbif_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .in_data_i   (tx_word),
    .in_valid_i  (tx_push),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .count_o     (fifo_cnt)
  );

  assign fifo_pop = fifo_out_valid && (!st.line_tx_valid || line_tx_ready_i);

  always_comb begin
    next_st = st;
    // output stage toward the lane side
    if (line_tx_ready_i || !st.line_tx_valid) begin
      next_st.line_tx_valid = fifo_out_valid;
      next_st.line_tx       = fifo_out;
    end
    // ready leaves room for the slack writes plus the ready latency
    next_st.tx_rdy = (fifo_cnt <= RDY_LIMIT);
    if (tx_push && !fifo_in_ready) begin
      next_st.tx_ovf = 1'b1;
    end
    // writes while ready is low; a fifth one breaks the back-pressure contract
    if (st.tx_rdy) begin
      next_st.slack = '0;
    end else if (tx_push) begin
      if (st.slack == SLACK_MAX) begin
        next_st.tx_ovf = 1'b1;
      end else begin
        next_st.slack = st.slack + 1'b1;
      end
    end
    next_st.rx_bus = rx_word;
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign line_tx_o       = st.line_tx;
  assign line_tx_valid_o = st.line_tx_valid;
  assign bus.tx_rdy      = st.tx_rdy;
  assign bus.tx_ovf      = st.tx_ovf;
  assign bus.rx_bus      = st.rx_bus;
endmodule
`default_nettype wire

// ==== spbif_usr.sv ====
// user end of the local_packet_bus
`timescale 1ns/100ps
`default_nettype none
module spbif_usr
  import spbif_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  spbif_if.usr            bus,
  input  wire spbif_bus_t app_tx_i,
  input  wire logic       app_tx_valid_i,
  output logic            app_tx_ready_o,
  output spbif_bus_t      app_rx_o,
  output logic            app_tx_ovf_o
);
  typedef struct packed {
    spbif_bus_t tx_bus;
    logic [2:0] slack;
    logic       ready;
    spbif_bus_t rx;
    logic       ovf;
  } spbif_usr_st_t;

  spbif_usr_st_t st;
  spbif_usr_st_t next_st;
  logic          accept;
  logic          chain;
  logic          wr_now;

  always_comb begin
    next_st = st;
    accept  = app_tx_valid_i && st.ready;
    chain   = 1'b1;
    wr_now  = st.tx_bus[0].valid;
    next_st.tx_bus = '0;
    if (accept) begin
      for (int i = 0; i < NSEG; i++) begin
        // drop segments after a gap so active ones stay packed from 0
        chain = chain & app_tx_i[i].valid;
        next_st.tx_bus[i] = chain ? spbif_qualify(app_tx_i[i]) : '0;
      end
    end
    // count writes made while ready is low
    if (bus.tx_rdy) begin
      next_st.slack = '0;
    end else if (wr_now) begin
      next_st.slack = st.slack + 1'b1;
    end
    next_st.ready = bus.tx_rdy ||
                    ((next_st.slack + {2'b00, accept}) < SLACK_MAX);
    for (int i = 0; i < NSEG; i++) begin
      next_st.rx[i] = spbif_qualify(bus.rx_bus[i]);
    end
    next_st.ovf = bus.tx_ovf;
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bus.tx_bus     = st.tx_bus;
  assign app_tx_ready_o = st.ready;
  assign app_rx_o       = st.rx;
  assign app_tx_ovf_o   = st.ovf;
endmodule
`default_nettype wire

// ==== spbif_dummy_unused.sv ====
// intentionally left without content
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ==== spbif_chk.sv ====
// assertions on the local_packet_bus carrier
`timescale 1ns/100ps
`default_nettype none
module spbif_chk
  import spbif_pkg::*;
(
  input wire logic       clk_sys_i,
  input wire logic       sys_rst_i,
  input wire spbif_bus_t tx_bus,
  input wire logic       tx_rdy,
  input wire logic       tx_ovf,
  input wire spbif_bus_t rx_bus
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  for (genvar s = 0; s < NSEG; s++) begin : g_seg
    AST_TXZ: assert property (!tx_bus[s].valid |-> tx_bus[s] == '0)
      else $error("tx segment junk while not valid");
    AST_TXE: assert property (tx_bus[s].err |-> tx_bus[s].valid && tx_bus[s].packet_last_transfer
      && tx_bus[s].mty[2:0] == 3'h0) else $error("tx error word malformed");
    AST_TXM: assert property (tx_bus[s].mty != 4'h0 |-> tx_bus[s].packet_last_transfer)
      else $error("tx empty count off last transfer");
    AST_RXZ: assert property (!rx_bus[s].valid |-> rx_bus[s] == '0)
      else $error("rx segment junk while not valid");
    AST_RXE: assert property (rx_bus[s].err |-> rx_bus[s].valid && rx_bus[s].packet_last_transfer
      && rx_bus[s].mty[2:0] == 3'h0) else $error("rx error word malformed");
    AST_RXM: assert property (rx_bus[s].mty != 4'h0 |-> rx_bus[s].packet_last_transfer)
      else $error("rx empty count off last transfer");
  end
  for (genvar s = 1; s < NSEG; s++) begin : g_gap
    AST_TXC: assert property (tx_bus[s].valid |-> tx_bus[s-1].valid)
      else $error("tx segments not contiguous");
  end
  AST_NOVF: assert property (!tx_ovf)
    else $error("tx overflow raised");
  // writes seen since tx_rdy last stood high
  logic [2:0] low_wr;
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || tx_rdy) begin
      low_wr <= '0;
    end else if (tx_bus[0].valid && low_wr != 3'h7) begin
      low_wr <= low_wr + 3'h1;
    end
  end
  AST_SLK: assert property (!tx_rdy && tx_bus[0].valid |-> low_wr < 3'h4)
    else $error("tx write beyond slack while not ready");
endmodule
`default_nettype wire

// ==== segmented_packet_bus_if_tb.sv ====
// self-checking bench of both bus ends
`timescale 1ns/100ps
`default_nettype none
module segmented_packet_bus_if_tb
  import spbif_pkg::*;
;
  logic       clk_sys_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic       on = 1'b0;
  logic       stall = 1'b0;
  logic       drop = 1'b0;
  logic       tv;
  logic       tr = 1'b0;
  logic       av = 1'b0;
  logic       ar;
  logic       ao;
  spbif_bus_t ai = '0;
  spbif_bus_t lr = '0;
  spbif_bus_t lt;
  spbif_bus_t ro;
  spbif_bus_t r1;
  spbif_bus_t r2;
  spbif_bus_t eq[$];
  int         num_errors = 0;
  int         checks_done = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  spbif_if spbif_if_i (.clk_sys_i(clk_sys_i));
  spbif_dev spbif_dev_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .bus(spbif_if_i.dev), .line_tx_o(lt),
    .line_tx_valid_o(tv), .line_tx_ready_i(tr), .line_rx_i(lr));
  spbif_usr spbif_usr_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .bus(spbif_if_i.usr), .app_tx_i(ai),
    .app_tx_valid_i(av), .app_tx_ready_o(ar), .app_rx_o(ro), .app_tx_ovf_o(ao));
  spbif_chk spbif_chk_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .tx_bus(spbif_if_i.tx_bus),
    .tx_rdy(spbif_if_i.tx_rdy), .tx_ovf(spbif_if_i.tx_ovf), .rx_bus(spbif_if_i.rx_bus));
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(logic [WORD_W-1:0] seen, logic [WORD_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // expected word: qualify, optionally cut after first idle segment
  function automatic spbif_bus_t q(spbif_bus_t w, logic cut);
    spbif_bus_t r;
    logic       g;
    r = w;
    g = 1'b1;
    for (int s = 0; s < NSEG; s++) begin
      g = cut ? g & w[s].valid : w[s].valid;
      if (!g) r[s] = '0;
      if (!(r[s].valid && r[s].packet_last_transfer)) begin
        r[s].err = 1'b0;
        r[s].mty = 4'h0;
      end
      if (r[s].err) r[s].mty[2:0] = 3'h0;
    end
    return r;
  endfunction
  function automatic spbif_bus_t rnd();
    spbif_bus_t       w;
    logic [159:0]     t;
    for (int s = 0; s < NSEG; s++) begin
      t = {$urandom, $urandom, $urandom, $urandom, $urandom};
      w[s] = t[$bits(spbif_seg_t)-1:0];
    end
    return w;
  endfunction
  task automatic send(spbif_bus_t w);
    int n;
    ai <= w;
    av <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (ar !== 1'b1 && n < 300);
    if (n >= 300) begin
      num_errors++;
      end_of_test();
    end
    w = q(w, 1'b1);
    if (w[0].valid) eq.push_back(w);
  endtask
  always @(posedge clk_sys_i) begin
    lr <= rnd();
    r1 <= q(lr, 1'b0);
    r2 <= r1;
    tr <= stall ? 1'b0 : ($urandom % 4) != 0;
    if (!sys_rst_i && tv && tr) begin
      if (eq.size() == 0) chk(lt, '1);
      else chk(lt, eq.pop_front());
    end
  end
  always @(negedge clk_sys_i) begin
    if (on) chk(spbif_if_i.rx_bus, r1);
    if (on) chk(ro, r2);
    if (stall && ar === 1'b0) drop = 1'b1;
  end
  logic [3:0] pat [4] = '{4'hd, 4'he, 4'h1, 4'hf};
  spbif_bus_t w;
  initial begin
    void'($urandom(12));
    repeat (10) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    on <= 1'b1;
    for (int i = 0; i < 60; i++) send(rnd());
    $display("test random tx done");
    foreach (pat[i]) begin
      w = rnd();
      for (int s = 0; s < NSEG; s++) begin
        w[s].valid = pat[i][s];
        w[s].err = i[0];
        w[s].mty = 4'hf;
      end
      send(w);
    end
    $display("test corner tx done");
    stall <= 1'b1;
    fork
      begin
        repeat (40) @(posedge clk_sys_i);
        stall <= 1'b0;
      end
    join_none
    for (int i = 0; i < 20; i++) send(rnd());
    av <= 1'b0;
    chk(WORD_W'(drop), WORD_W'(1'b1));
    for (int n = 0; n < 500 && eq.size() != 0; n++) @(posedge clk_sys_i);
    chk(WORD_W'(eq.size()), '0);
    chk(WORD_W'(ao), '0);
    $display("test fill and drain done");
    end_of_test();
  end
endmodule
`default_nettype wire
